// File: hw/sac_conv_ctrl.sv
// Control logic of a 10-bit successive-approximation converter with an
// AXI4-Lite register slave. The analog comparator is outside; it answers
// each approximation step through cmp_high_i.
// Function
// - Ten-bit successive approximation, zero is ground, full scale is reference minus one.
// - Reference field picks external pin, analog supply, 1.1V or 2.56V.
// - Channel bits span channel register and control B; pins, ground, bandgap.
// - Differential pair drives converter through amplifier; single-ended bypasses it.
// - Four differential pairs offer gain 1, 10 or 200.
// - Two groups of eight inputs, each with one shared negative input.
// - Selections act only while enabled; disabled converter draws no power.
// - Converter works only when the power reduction bit is zero.
// - Result right-aligned by default, left-aligned with left_adjust.
// - Low byte read blocks result updates; blocked completions are discarded.
// - High byte read lifts the block.
// - Completion sets the flag even when the result is discarded.
// - Start bit begins one conversion, stays set, clears on completion except when free running.
// - Channel change mid-conversion applies only after completion.
// - Auto-trigger enable allows starts from the trigger select source.
// - Rising trigger edge resets the prescaler and starts a conversion.
// - Trigger still high at completion starts nothing; needs a fresh edge.
// - Trigger edges during a conversion are ignored.
// - Trigger flags set regardless of enables; clear before the next start.
// - Completion flag as trigger gives free running after a first start.
// - Start bit works in auto mode and reads one during any conversion.
// - Normal conversion takes 13 converter clocks, first after enable 25.
// - Completion writes result, sets flag and, unless free running, clears start bit together.
// - Prescaler runs while enabled and is held in reset while disabled.
`timescale 1ns/10ps
`default_nettype none
module sac_conv_ctrl #(
  parameter int NSRC = 8 // Number of trigger sources.
) (
  input wire logic clk_sys_i, // System clock, 25 MHz.
  input wire logic rst_n_i, // Synchronous reset, active low.
  input wire logic [7:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [7:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic [NSRC-1:0] trig_src_i, // Trigger source flags.
  input wire logic cmp_high_i, // Comparator: input above DAC level.
  output logic [9:0] dac_code_o, // Trial code to the DAC.
  output logic sample_hold_o, // Sample-and-hold active.
  output logic [1:0] reference_select_o, // Applied reference select.
  output logic [5:0] channel_select_bits_o, // Applied channel select.
  output logic analog_power_o, // Analog circuitry powered.
  output logic conv_complete_flag_o // Completion flag level.
);
  typedef enum logic [1:0] {
    SAC_IDLE = 2'b00,
    SAC_RUN = 2'b01
  } sac_state_e;
  sac_state_e state;
  logic [7:0] chan_ref;
  logic [7:0] ctrl_a;
  logic [7:0] ctrl_b;
  logic conv_power_reduction;
  logic conv_enable;
  logic conv_start;
  logic conv_complete_flag;
  logic first_conv;
  logic [9:0] result;
  logic [7:0] result_high_byte;
  logic [7:0] result_low_byte;
  logic result_locked;
  logic [6:0] presc;
  logic [4:0] cyc;
  logic [3:0] bitpos;
  logic trig_prev;
  logic trig_sel;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic rd_fire;
  logic wr_ok;
  logic start_req;
  logic trig_edge;
  logic cck;
  logic done;
  logic [6:0] presc_div;
  // Trigger select maps straight onto the source index.
  function automatic logic pick_src(input logic [NSRC-1:0] src, input logic [2:0] sel);
    pick_src = src[sel];
  endfunction
  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == sac_pkg::ADDR_CHAN_REF) || (a == sac_pkg::ADDR_CTRL_A) ||
      (a == sac_pkg::ADDR_CTRL_B) || (a == sac_pkg::ADDR_RES_LOW) ||
      (a == sac_pkg::ADDR_RES_HIGH) || (a == sac_pkg::ADDR_POWER);
  endfunction
  assign conv_enable = ctrl_a[sac_pkg::CA_ENABLE] && !conv_power_reduction;
  // Write channel: address and data may arrive in either order.
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_fire = (aw_held || s_axi_awvalid) && (w_held || s_axi_wvalid) && !s_axi_bvalid;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sac_pkg::AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_known(aw_held ? aw_addr : s_axi_awaddr) ? sac_pkg::AXI_OKAY : sac_pkg::AXI_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  logic [7:0] wa;
  logic [7:0] wd;
  assign wa = aw_held ? aw_addr : s_axi_awaddr;
  assign wd = w_held ? w_data[7:0] : s_axi_wdata[7:0];
  assign wr_ok = wr_fire && (w_held ? w_strb[0] : s_axi_wstrb[0]);
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      chan_ref <= sac_pkg::RESET_BYTE;
      ctrl_a <= sac_pkg::RESET_BYTE;
      ctrl_b <= sac_pkg::RESET_BYTE;
      conv_power_reduction <= sac_pkg::POWER_RESET;
    end else if (wr_ok) begin
      case (wa)
        sac_pkg::ADDR_CHAN_REF: chan_ref <= wd;
        sac_pkg::ADDR_CTRL_A: ctrl_a <= wd;
        sac_pkg::ADDR_CTRL_B: ctrl_b <= wd;
        sac_pkg::ADDR_POWER: conv_power_reduction <= wd[0];
        default: ctrl_b <= ctrl_b;
      endcase
    end
  end
  // Read channel; reading the result bytes has side effects on the lock.
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= sac_pkg::AXI_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= addr_known(s_axi_araddr) ? sac_pkg::AXI_OKAY : sac_pkg::AXI_SLVERR;
      case (s_axi_araddr)
        sac_pkg::ADDR_CHAN_REF: s_axi_rdata <= {24'h000000, chan_ref};
        sac_pkg::ADDR_CTRL_A: s_axi_rdata <= {24'h000000, ctrl_a[7], conv_start, ctrl_a[5],
          conv_complete_flag, ctrl_a[3:0]};
        sac_pkg::ADDR_CTRL_B: s_axi_rdata <= {24'h000000, 4'h0, ctrl_b[3:0]};
        sac_pkg::ADDR_RES_LOW: s_axi_rdata <= {24'h000000, result_low_byte};
        sac_pkg::ADDR_RES_HIGH: s_axi_rdata <= {24'h000000, result_high_byte};
        sac_pkg::ADDR_POWER: s_axi_rdata <= {31'h00000000, conv_power_reduction};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  // Prescaler: held in reset while disabled, restarted by a trigger edge.
  always_comb begin
    case (ctrl_a[2:0])
      3'h0, 3'h1: presc_div = 7'h01;
      3'h2: presc_div = 7'h03;
      3'h3: presc_div = 7'h07;
      3'h4: presc_div = 7'h0f;
      3'h5: presc_div = 7'h1f;
      3'h6: presc_div = 7'h3f;
      default: presc_div = 7'h7f;
    endcase
  end
  assign cck = conv_enable && (presc == presc_div);
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !conv_enable || trig_edge) begin
      presc <= 7'h00;
    end else if (cck) begin
      presc <= 7'h00;
    end else begin
      presc <= presc + 7'h01;
    end
  end
  assign trig_sel = (ctrl_b[2:0] == sac_pkg::TRIG_FREE_RUN) ? conv_complete_flag :
    pick_src(trig_src_i, ctrl_b[2:0]);
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      trig_prev <= 1'b0;
    end else begin
      trig_prev <= trig_sel;
    end
  end
  // Edges count only when idle; a level held high never restarts.
  assign trig_edge = conv_enable && ctrl_a[sac_pkg::CA_AUTO] && trig_sel && !trig_prev &&
    (state == SAC_IDLE) && (ctrl_b[2:0] != sac_pkg::TRIG_FREE_RUN);
  assign done = (state == SAC_RUN) && cck &&
    (cyc == (first_conv ? 5'(sac_pkg::FIRST_CYCLES - 1) : 5'(sac_pkg::NORMAL_CYCLES - 1)));
  assign start_req = wr_ok && (wa == sac_pkg::ADDR_CTRL_A) && wd[sac_pkg::CA_START];
  // Start bit: set by software or trigger, cleared at completion unless free running.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      conv_start <= 1'b0;
    end else if (start_req || trig_edge) begin
      // A start written together with the enable bit must not be lost.
      conv_start <= 1'b1;
    end else if (!conv_enable) begin
      conv_start <= 1'b0;
    end else if (done) begin
      conv_start <= ctrl_a[sac_pkg::CA_AUTO] && (ctrl_b[2:0] == sac_pkg::TRIG_FREE_RUN);
    end
  end
  // Conversion sequencer on converter clock enables.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !conv_enable) begin
      state <= SAC_IDLE;
      cyc <= 5'h00;
      bitpos <= 4'h9;
      result <= 10'h000;
      first_conv <= 1'b1;
      reference_select_o <= 2'h0;
      channel_select_bits_o <= 6'h00;
    end else begin
      case (state)
        SAC_IDLE: begin
          reference_select_o <= chan_ref[7:6];
          channel_select_bits_o <= {ctrl_b[sac_pkg::CB_CHAN_HI], chan_ref[4:0]};
          if (conv_start && cck) begin
            state <= SAC_RUN;
            cyc <= 5'h00;
            bitpos <= 4'h9;
            result <= 10'h200;
          end
        end
        SAC_RUN: begin
          if (cck) begin
            cyc <= cyc + 5'h01;
            if (cyc >= 5'h02 && bitpos != 4'hf) begin
              if (!cmp_high_i) begin
                result[bitpos] <= 1'b0;
              end
              if (bitpos != 4'h0) begin
                result[bitpos - 4'h1] <= 1'b1;
              end
              bitpos <= bitpos - 4'h1;
            end
            if (done) begin
              first_conv <= 1'b0;
              state <= SAC_IDLE;
            end
          end
        end
        default: state <= SAC_IDLE;
      endcase
    end
  end
  // Completion flag: set wins over a write-one clear.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      conv_complete_flag <= 1'b0;
    end else if (done) begin
      conv_complete_flag <= 1'b1;
    end else if (wr_ok && wa == sac_pkg::ADDR_CTRL_A && wd[sac_pkg::CA_FLAG]) begin
      conv_complete_flag <= 1'b0;
    end
  end
  // Result bytes with low-byte-read lock.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      result_locked <= 1'b0;
    end else if (rd_fire && s_axi_araddr == sac_pkg::ADDR_RES_LOW) begin
      result_locked <= 1'b1;
    end else if (rd_fire && s_axi_araddr == sac_pkg::ADDR_RES_HIGH) begin
      result_locked <= 1'b0;
    end
  end
  // A low byte read in the completion cycle already blocks that result.
  logic lock_now;
  assign lock_now = result_locked || (rd_fire && s_axi_araddr == sac_pkg::ADDR_RES_LOW);
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      result_high_byte <= 8'h00;
      result_low_byte <= 8'h00;
    end else if (done && !lock_now) begin
      if (chan_ref[sac_pkg::CR_LEFT_ADJ]) begin
        result_high_byte <= result[9:2];
        result_low_byte <= {result[1:0], 6'h00};
      end else begin
        result_high_byte <= {6'h00, result[9:8]};
        result_low_byte <= result[7:0];
      end
    end
  end
  assign dac_code_o = result;
  assign sample_hold_o = (state == SAC_RUN) && (cyc < 5'h02);
  assign analog_power_o = conv_enable;
  assign conv_complete_flag_o = conv_complete_flag;

  property p_start_clears;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      done && !ctrl_a[sac_pkg::CA_AUTO] && !start_req |=> !conv_start;
  endproperty
  a_start_clears: assert property (p_start_clears) else $error("start bit not cleared");
  property p_flag_set;
    @(posedge clk_sys_i) disable iff (!rst_n_i) done |=> conv_complete_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set on completion");
  property p_locked_hold;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      result_locked && !rd_fire |=> $stable(result_low_byte) && $stable(result_high_byte);
  endproperty
  a_locked_hold: assert property (p_locked_hold) else $error("locked result changed");
  property p_unlock;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      rd_fire && s_axi_araddr == sac_pkg::ADDR_RES_HIGH |=> !result_locked;
  endproperty
  a_unlock: assert property (p_unlock) else $error("high read did not unlock");
  property p_chan_stable;
    @(posedge clk_sys_i) disable iff (!rst_n_i || !conv_enable)
      state == SAC_RUN |=> $stable(channel_select_bits_o);
  endproperty
  a_chan_stable: assert property (p_chan_stable) else $error("channel changed mid conversion");
  property p_presc_held;
    @(posedge clk_sys_i) disable iff (!rst_n_i) !conv_enable |=> presc == 7'h00;
  endproperty
  a_presc_held: assert property (p_presc_held) else $error("prescaler ran while disabled");
  property p_no_power;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      conv_power_reduction |-> !analog_power_o ##1 state == SAC_IDLE;
  endproperty
  a_no_power: assert property (p_no_power) else $error("converter ran while power reduced");
  property p_start_reads;
    @(posedge clk_sys_i) disable iff (!rst_n_i) state == SAC_RUN |-> conv_start;
  endproperty
  a_start_reads: assert property (p_start_reads) else $error("start bit low during conversion");
  property p_align;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      done && !lock_now && !chan_ref[sac_pkg::CR_LEFT_ADJ] |=> result_high_byte[7:2] == 6'h00;
  endproperty
  a_align: assert property (p_align) else $error("right alignment wrong");
  property p_lock_set;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      rd_fire && s_axi_araddr == sac_pkg::ADDR_RES_LOW |=> result_locked;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("low read did not lock");
  property p_trig_restart;
    @(posedge clk_sys_i) disable iff (!rst_n_i) trig_edge |=> presc == 7'h00 && conv_start;
  endproperty
  a_trig_restart: assert property (p_trig_restart) else $error("trigger edge did not restart");
  property p_free_run;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      done && ctrl_a[sac_pkg::CA_AUTO] && ctrl_b[2:0] == sac_pkg::TRIG_FREE_RUN |=> conv_start;
  endproperty
  a_free_run: assert property (p_free_run) else $error("free running did not restart");
endmodule
`default_nettype wire

// File: hw/sac_pkg.sv
// Constants for the converter control block: register map, field positions,
// reset values and conversion timing.
// Assumes a 32-bit AXI4-Lite register bus and one system clock.
package sac_pkg;
  localparam logic [7:0] ADDR_CHAN_REF = 8'h00;
  localparam logic [7:0] ADDR_CTRL_A = 8'h04;
  localparam logic [7:0] ADDR_CTRL_B = 8'h08;
  localparam logic [7:0] ADDR_RES_LOW = 8'h0c;
  localparam logic [7:0] ADDR_RES_HIGH = 8'h10;
  localparam logic [7:0] ADDR_POWER = 8'h14;
  // Channel and reference register fields.
  localparam int CR_CHAN_LSB = 0;
  localparam int CR_LEFT_ADJ = 5;
  localparam int CR_REF_LSB = 6;
  // Control register A fields.
  localparam int CA_PRESC_LSB = 0;
  localparam int CA_FLAG = 4;
  localparam int CA_AUTO = 5;
  localparam int CA_START = 6;
  localparam int CA_ENABLE = 7;
  // Control register B fields.
  localparam int CB_TRIG_LSB = 0;
  localparam int CB_CHAN_HI = 3;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic POWER_RESET = 1'b1;
  localparam int RES_WIDTH = 10;
  localparam int NORMAL_CYCLES = 13;
  localparam int FIRST_CYCLES = 25;
  // Trigger select value that picks the completion flag (free running).
  localparam logic [2:0] TRIG_FREE_RUN = 3'h0;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

// File: verification/sac_conv_ctrl_bench.sv
// Self-checking bench for the converter control block.
// Drives the AXI4-Lite slave, the trigger inputs and a comparator model.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module sac_conv_ctrl_bench;
  typedef struct {string nm; logic [31:0] exp; logic [31:0] msk; logic [1:0] rsp;} sac_note_s;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [7:0] trig = 8'h00;
  logic cmp_high_i = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [9:0] dac_code_o;
  logic sample_hold_o, analog_power_o, conv_complete_flag_o;
  logic [1:0] reference_select_o;
  logic [5:0] channel_select_bits_o;
  logic [9:0] vin = 10'h0;
  logic [31:0] seed = 32'hbdf2;
  logic sh_q = 1'b0;
  int starts = 0;
  int cyc = 0;
  int err_total = 0;
  int tests_run = 0;
  sac_note_s notes[$];
  sac_note_s note;
  logic [1:0] bnotes[$];
  logic [1:0] bexp;

  sac_conv_ctrl #(.NSRC(8)) i_sac_conv_ctrl (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(rready), .trig_src_i(trig), .cmp_high_i(cmp_high_i), .dac_code_o(dac_code_o),
    .sample_hold_o(sample_hold_o), .reference_select_o(reference_select_o),
    .channel_select_bits_o(channel_select_bits_o), .analog_power_o(analog_power_o),
    .conv_complete_flag_o(conv_complete_flag_o)
  );

  always #20 clk_sys_i = ~clk_sys_i;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  // Comparator model: the analog input is vin, so a correct search returns vin.
  always @(posedge clk_sys_i) begin
    cmp_high_i <= (vin >= dac_code_o);
    sh_q <= sample_hold_o;
    cyc <= cyc + 1;
    if (sample_hold_o === 1'b1 && sh_q === 1'b0)
      starts <= starts + 1;
  end

  // Read results and write responses are compared against the oldest notes of the driver.
  always @(posedge clk_sys_i) begin
    if (s_axi_bvalid === 1'b1 && bready === 1'b1 && bnotes.size() != 0) begin
      bexp = bnotes.pop_front();
      `CHK("write response", bexp, s_axi_bresp)
    end
    if (s_axi_rvalid === 1'b1 && rready === 1'b1) begin
      if (notes.size() == 0) begin
        `CHK("unexpected read data", 1'b0, 1'b1)
      end else begin
        note = notes.pop_front();
        `CHK(note.nm, note.exp & note.msk, s_axi_rdata & note.msk)
        `CHK(note.nm, note.rsp, s_axi_rresp)
      end
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = sac_pkg::AXI_OKAY);
    logic aw_ok, w_ok;
    bnotes.push_back(r);
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_sys_i);
      if (awvalid && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk_sys_i); while (s_axi_bvalid !== 1'b1);
    bready <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input string nm,
                    input logic [1:0] r = sac_pkg::AXI_OKAY);
    notes.push_back('{nm, e, m, r});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_sys_i); while (s_axi_arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_sys_i); while (s_axi_rvalid !== 1'b1);
    rready <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  // New random input, then a control A write that starts a conversion.
  task automatic convert(input logic [7:0] ctl);
    seed = xs(seed);
    vin <= seed[9:0];
    wr(sac_pkg::ADDR_CTRL_A, {24'h0, ctl});
  endtask

  task automatic wait_flag();
    while (conv_complete_flag_o !== 1'b1)
      @(posedge clk_sys_i);
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    err_total++;
    give_verdict();
  end

  initial begin
    int t0;
    int n;
    int s0;
    logic [9:0] old;
    repeat (16) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    rd(sac_pkg::ADDR_POWER, {31'h0, sac_pkg::POWER_RESET}, 32'h1, "power reset");
    rd(sac_pkg::ADDR_CTRL_A, 32'h0, 32'hff, "ctrl a reset");
    rd(sac_pkg::ADDR_CTRL_B, 32'h0, 32'hff, "ctrl b reset");
    rd(8'h18, 32'h0, 32'hffffffff, "unmapped read", sac_pkg::AXI_SLVERR);
    wr(8'h18, 32'h0, sac_pkg::AXI_SLVERR);
    wr(sac_pkg::ADDR_CHAN_REF, 32'h43);
    repeat (4) @(posedge clk_sys_i);
    `CHK("reference while disabled", 2'h0, reference_select_o)
    wr(sac_pkg::ADDR_CTRL_A, 32'h80);
    repeat (4) @(posedge clk_sys_i);
    `CHK("power with reduction set", 1'b0, analog_power_o)
    wr(sac_pkg::ADDR_POWER, 32'h0);
    repeat (4) @(posedge clk_sys_i);
    `CHK("power enabled", 1'b1, analog_power_o)
    `CHK("reference applied", 2'h1, reference_select_o)
    `CHK("channel applied", 6'h03, channel_select_bits_o)
    convert(8'hd0);
    t0 = cyc;
    rd(sac_pkg::ADDR_CTRL_A, 32'h40, 32'h40, "start while busy");
    wait_flag();
    n = cyc - t0;
    `CHK("first length", 1'b1, n >= 2 * sac_pkg::FIRST_CYCLES - 4 && n <= 2 * sac_pkg::FIRST_CYCLES + 8)
    rd(sac_pkg::ADDR_CTRL_A, 32'h10, 32'h50, "start cleared, flag set");
    rd(sac_pkg::ADDR_RES_LOW, {24'h0, vin[7:0]}, 32'hff, "low right");
    rd(sac_pkg::ADDR_RES_HIGH, {30'h0, vin[9:8]}, 32'hff, "high right");
    wr(sac_pkg::ADDR_CHAN_REF, 32'h63);
    convert(8'hd0);
    t0 = cyc;
    wait_flag();
    n = cyc - t0;
    `CHK("normal length", 1'b1, n >= 2 * sac_pkg::NORMAL_CYCLES - 4 && n <= 2 * sac_pkg::NORMAL_CYCLES + 8)
    rd(sac_pkg::ADDR_RES_LOW, {24'h0, vin[1:0], 6'h0}, 32'hff, "low left");
    rd(sac_pkg::ADDR_RES_HIGH, {24'h0, vin[9:2]}, 32'hff, "high left");
    rd(sac_pkg::ADDR_RES_LOW, {24'h0, vin[1:0], 6'h0}, 32'hff, "low locks");
    old = vin;
    convert(8'hd0);
    t0 = cyc;
    wr(sac_pkg::ADDR_CHAN_REF, 32'h65);
    `CHK("channel held mid conversion", 6'h03, channel_select_bits_o)
    wait_flag();
    `CHK("flag on discarded result", 1'b1, cyc - t0 <= 2 * sac_pkg::NORMAL_CYCLES + 8)
    repeat (4) @(posedge clk_sys_i);
    `CHK("channel after conversion", 6'h05, channel_select_bits_o)
    rd(sac_pkg::ADDR_RES_HIGH, {24'h0, old[9:2]}, 32'hff, "high kept while locked");
    convert(8'hd0);
    wait_flag();
    rd(sac_pkg::ADDR_RES_LOW, {24'h0, vin[1:0], 6'h0}, 32'hff, "low after unlock");
    rd(sac_pkg::ADDR_RES_HIGH, {24'h0, vin[9:2]}, 32'hff, "high after unlock");
    wr(sac_pkg::ADDR_CTRL_B, 32'h1);
    wr(sac_pkg::ADDR_CTRL_A, 32'hb0);
    s0 = starts;
    trig <= 8'h02;
    repeat (6) @(posedge clk_sys_i);
    rd(sac_pkg::ADDR_CTRL_A, 32'h40, 32'h40, "start in auto conversion");
    trig <= 8'h00;
    repeat (2) @(posedge clk_sys_i);
    trig <= 8'h02;
    wait_flag();
    wr(sac_pkg::ADDR_CTRL_A, 32'hb0);
    repeat (80) @(posedge clk_sys_i);
    `CHK("one start per edge", s0 + 1, starts)
    trig <= 8'h00;
    repeat (2) @(posedge clk_sys_i);
    trig <= 8'h02;
    wait_flag();
    repeat (4) @(posedge clk_sys_i);
    `CHK("fresh edge starts", s0 + 2, starts)
    wr(sac_pkg::ADDR_CTRL_B, {29'h0, sac_pkg::TRIG_FREE_RUN});
    s0 = starts;
    wr(sac_pkg::ADDR_CTRL_A, 32'he0);
    repeat (200) @(posedge clk_sys_i);
    `CHK("free running", 1'b1, starts >= s0 + 5)
    wr(sac_pkg::ADDR_CTRL_A, 32'h80);
    repeat (60) @(posedge clk_sys_i);
    wr(sac_pkg::ADDR_CTRL_A, 32'h0);
    convert(8'hd0);
    t0 = cyc;
    wait_flag();
    n = cyc - t0;
    `CHK("first length again", 1'b1, n >= 2 * sac_pkg::FIRST_CYCLES - 4 && n <= 2 * sac_pkg::FIRST_CYCLES + 8)
    wr(sac_pkg::ADDR_CTRL_A, 32'h0);
    repeat (4) @(posedge clk_sys_i);
    `CHK("power off when disabled", 1'b0, analog_power_o)
    give_verdict();
  end
endmodule
`default_nettype wire
